//--- core/flash_read_front.sv
// Read command front end: dual/quad I/O fast reads, opcode skipping, burst wrap
// Summary of operation
// R1: Dual read takes address and mode two bits per clock, returns two bits per clock.
// R2: Reads start at any byte and advance one address per byte while selected.
// R3: Dual read with mode bits not 10 needs a full opcode next time.
// R4: Mode bits 10 let the next transaction start directly with the address.
// R5: A mode reset sequence clears opcode skipping before ordinary commands.
// R6: Quad read takes address, mode, four dummy clocks, returns four bits per clock.
// R7: Quad read is accepted only while the quad enable bit is set; the code takes a skip-mode frame without checking the bit.
// R8: Quad read uses the same mode byte rule for opcode skipping.
// R9: Host sends even start address for word read; two dummy clocks.
// R10: Word read is accepted only while status bit nine is set; the code takes a skip-mode frame without checking the bit.
// R11: Word read uses the same opcode skipping rule.
// R12: With wrap on, quad reads loop inside an aligned section until deselect.
// R13: The stored wrap setting holds for all later quad reads until changed.
// R14: Set-burst: opcode, 24 dummy bits, 8 wrap bits; captured at deselect.
// R15: Wrap disable bit zero enables; length bits choose 8, 16, 32 or 64.
// R16: After power-on wrapping is disabled.
// R17: Wrap bits sit on lines 0, 1, 2 in the seventh slot.
// R18: In skip mode the first clocks are address bits of the previous read type.
// R19: With wrap off, quad reads stream linearly across pages.
`timescale 1ns/1ns
module flash_read_front (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_enable_bit,
    output logic [23:0] mem_addr,
    input wire logic [7:0] mem_data,
    output logic skip_active,
    output flash_read_pkg::wrap_cfg_t wrap_setting
);
    import flash_read_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] wrap_mask(input logic [1:0] len);
        case (len) // R15
            2'b00: wrap_mask = MASK_8;
            2'b01: wrap_mask = MASK_16;
            2'b10: wrap_mask = MASK_32;
            default: wrap_mask = MASK_64;
        endcase
    endfunction

    function automatic logic [4:0] addr_last(input read_kind_t k);
        addr_last = (k == RK_DUAL) ? ADDR_LAST_DUAL : ADDR_LAST_QUAD;
    endfunction

    function automatic logic [4:0] dummy_len(input read_kind_t k);
        case (k)
            RK_QUAD: dummy_len = DUMMY_QUAD; // R6
            RK_WORD: dummy_len = DUMMY_WORD; // R9
            default: dummy_len = DUMMY_DUAL;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic sck_s1_ff, sck_s2_ff, sck_d_ff;
    logic cs_s1_ff, cs_s2_ff, cs_d_ff;
    logic [3:0] io_s1_ff, io_s2_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {sck_s1_ff, sck_s2_ff, sck_d_ff} <= 3'h0;
            {cs_s1_ff, cs_s2_ff, cs_d_ff} <= 3'h7;
            io_s1_ff <= 4'h0;
            io_s2_ff <= 4'h0;
        end else if (ce) begin
            {sck_s1_ff, sck_s2_ff, sck_d_ff} <= {sck, sck_s1_ff, sck_s2_ff};
            {cs_s1_ff, cs_s2_ff, cs_d_ff} <= {cs_n, cs_s1_ff, cs_s2_ff};
            io_s1_ff <= io_in;
            io_s2_ff <= io_s1_ff;
        end
    end

    wire logic cs_rise = cs_s2_ff & ~cs_d_ff;
    wire logic cs_fall = ~cs_s2_ff & cs_d_ff;
    wire logic sck_rise = sck_s2_ff & ~sck_d_ff & ~cs_s2_ff;
    wire logic sck_fall = ~sck_s2_ff & sck_d_ff & ~cs_s2_ff;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    read_state_t st_ff, nxt_st;
    read_kind_t kind_ff, nxt_kind, skip_kind_ff, nxt_skip_kind;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [31:0] sh_ff, nxt_sh;
    logic skip_ff, nxt_skip;
    logic all1_ff, nxt_all1;
    wrap_cfg_t wrap_cfg_ff, nxt_wrap, pend_ff, nxt_pend;
    logic fetch_en_ff, nxt_fetch_en;
    logic [23:0] fetch_addr_ff, nxt_fetch_addr;
    logic [7:0] out_sh_ff, nxt_out_sh;
    logic [1:0] slot_ff, nxt_slot;
    io_drive_t drv_ff, nxt_drv;

    wire logic is_dual = (kind_ff == RK_DUAL);
    wire logic [31:0] sh_lane = is_dual ? {sh_ff[29:0], io_s2_ff[1:0]}
                                        : {sh_ff[27:0], io_s2_ff};
    wire logic lanes_high = is_dual ? &io_s2_ff[1:0] : &io_s2_ff;
    wire logic [7:0] opc = {sh_ff[6:0], io_s2_ff[0]};
    wire logic opc_done = ce & sck_rise & (st_ff == ST_OPC) & (cnt_ff == OPC_LAST);
    wire logic mode_end = ce & sck_rise & (st_ff == ST_ADDR) & (cnt_ff == addr_last(kind_ff));
    wire logic [1:0] skip_bits = sh_lane[MODE_SKIP_LO +: 2];
    wire logic wrap_commit = ce & cs_rise & (st_ff == ST_WRAP) & (cnt_ff == WRAP_CLOCKS);
    wire logic mode_reset = ce & cs_rise & (st_ff == ST_ADDR) & skip_ff & all1_ff;
    wire logic quad_opc = (opc == OPC_QUAD_IO) | (opc == OPC_QUAD_WORD);

    // ------------------------------------------------------------
    // Fetch path and buffer
    // ------------------------------------------------------------
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_data;
    wire logic wrap_on = ~wrap_cfg_ff.dis & ~is_dual; // R12 R19
    wire logic [23:0] cur_mask = wrap_mask(wrap_cfg_ff.len);
    wire logic [23:0] wrap_base = fetch_addr_ff & ~cur_mask;
    wire logic [23:0] step_addr = fetch_addr_ff + ADDR_STEP; // R2
    wire logic [23:0] next_addr = wrap_on ? (wrap_base | (step_addr & cur_mask)) : step_addr;
    wire logic push = ce & fetch_en_ff & fifo_in_ready & ~cs_rise;
    wire logic pop = ce & sck_fall & (st_ff == ST_DATA) & (slot_ff == 2'd0) & ~cs_rise;

    // Fetch fills the buffer ahead of the link and never stalls the read; back-pressure holds the address.
    stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .flush(cs_rise),
        .in_valid(fetch_en_ff),
        .in_ready(fifo_in_ready),
        .in_data(mem_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // Underrun sends zeros; array is expected to keep up at this link rate.
    wire logic [7:0] load_byte = fifo_out_valid ? fifo_data : 8'h00;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_kind = kind_ff;
        nxt_skip_kind = skip_kind_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_skip = skip_ff;
        nxt_all1 = all1_ff;
        nxt_wrap = wrap_cfg_ff;
        nxt_pend = pend_ff;
        nxt_fetch_en = fetch_en_ff;
        nxt_fetch_addr = push ? next_addr : fetch_addr_ff;
        nxt_out_sh = out_sh_ff;
        nxt_slot = slot_ff;
        nxt_drv = drv_ff;
        if (cs_rise) begin
            nxt_st = ST_IDLE;
            nxt_fetch_en = 1'b0;
            nxt_drv = '0;
            // Trailing fall pops a byte; next frame must start on a byte boundary
            nxt_slot = 2'd0;
            if (wrap_commit) begin
                nxt_wrap = pend_ff; // R14
            end
            if (mode_reset) begin
                nxt_skip = 1'b0; // R5
            end
        end else if (cs_fall) begin
            nxt_cnt = 5'd0;
            nxt_all1 = 1'b1;
            if (skip_ff) begin
                nxt_st = ST_ADDR; // R18
                nxt_kind = skip_kind_ff;
            end else begin
                nxt_st = ST_OPC;
            end
        end else if (sck_rise) begin
            nxt_cnt = cnt_ff + 5'd1;
            case (st_ff)
                ST_OPC: begin
                    nxt_sh = {sh_ff[30:0], io_s2_ff[0]};
                    if (cnt_ff == OPC_LAST) begin
                        nxt_cnt = 5'd0;
                        nxt_st = ST_IGNORE;
                        case (opc)
                            OPC_DUAL_IO: begin
                                nxt_st = ST_ADDR; // R1
                                nxt_kind = RK_DUAL;
                            end
                            OPC_QUAD_IO: begin
                                nxt_st = quad_enable_bit ? ST_ADDR : ST_IGNORE; // R7
                                nxt_kind = RK_QUAD;
                            end
                            OPC_QUAD_WORD: begin
                                nxt_st = quad_enable_bit ? ST_ADDR : ST_IGNORE; // R10
                                nxt_kind = RK_WORD;
                            end
                            OPC_SET_BURST: begin
                                nxt_st = ST_WRAP;
                                nxt_pend = wrap_cfg_ff;
                            end
                            OPC_MODE_RESET: begin
                                nxt_skip = 1'b0; // R5
                            end
                            default: begin
                                nxt_st = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    nxt_sh = sh_lane; // R1 R6
                    nxt_all1 = all1_ff & lanes_high;
                    if (mode_end) begin
                        nxt_cnt = 5'd0;
                        nxt_skip = (skip_bits == SKIP_CODE); // R3 R4 R8 R11
                        nxt_skip_kind = kind_ff;
                        nxt_fetch_addr = sh_lane[31:8]; // R2
                        nxt_fetch_en = 1'b1;
                        nxt_st = (dummy_len(kind_ff) == 5'd0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (cnt_ff == dummy_len(kind_ff) - 5'd1) begin
                        nxt_st = ST_DATA; // R6 R9
                    end
                end
                ST_WRAP: begin
                    if (cnt_ff == WRAP_SLOT) begin
                        nxt_pend = '{dis: io_s2_ff[0], len: io_s2_ff[2:1]}; // R17
                    end
                    if (cnt_ff == WRAP_CLOCKS) begin
                        nxt_cnt = cnt_ff;
                    end
                end
                default: begin
                    nxt_cnt = cnt_ff;
                end
            endcase
        end else if (sck_fall && st_ff == ST_DATA) begin
            if (pop) begin
                nxt_slot = is_dual ? SLOTS_DUAL : SLOTS_QUAD;
                nxt_drv.drive = is_dual ? {2'b00, load_byte[7:6]} : load_byte[7:4];
                nxt_out_sh = is_dual ? {load_byte[5:0], 2'b00} : {load_byte[3:0], 4'h0};
            end else begin
                nxt_slot = slot_ff - 2'd1;
                nxt_drv.drive = is_dual ? {2'b00, out_sh_ff[7:6]} : out_sh_ff[7:4];
                nxt_out_sh = is_dual ? {out_sh_ff[5:0], 2'b00} : {out_sh_ff[3:0], 4'h0};
            end
            nxt_drv.enable = is_dual ? 4'h3 : 4'hf; // R1 R6
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            kind_ff <= RK_DUAL;
            skip_kind_ff <= RK_DUAL;
            cnt_ff <= 5'd0;
            sh_ff <= 32'h0;
            skip_ff <= 1'b0;
            all1_ff <= 1'b0;
        end else if (ce) begin
            st_ff <= nxt_st;
            kind_ff <= nxt_kind;
            skip_kind_ff <= nxt_skip_kind;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            skip_ff <= nxt_skip;
            all1_ff <= nxt_all1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_cfg_ff <= WRAP_RESET; // R16
            pend_ff <= WRAP_RESET;
            fetch_en_ff <= 1'b0;
            fetch_addr_ff <= 24'h0;
            out_sh_ff <= 8'h0;
            slot_ff <= 2'd0;
            drv_ff <= '0;
        end else if (ce) begin
            wrap_cfg_ff <= nxt_wrap; // R13
            pend_ff <= nxt_pend;
            fetch_en_ff <= nxt_fetch_en;
            fetch_addr_ff <= nxt_fetch_addr;
            out_sh_ff <= nxt_out_sh;
            slot_ff <= nxt_slot;
            drv_ff <= nxt_drv;
        end
    end

    assign io_out = drv_ff.drive;
    assign io_oe = drv_ff.enable;
    assign mem_addr = fetch_addr_ff;
    assign skip_active = skip_ff;
    assign wrap_setting = wrap_cfg_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic wrap_seen_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_seen_ff <= 1'b0;
        end else if (wrap_commit) begin
            wrap_seen_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_skip_fall;
        ce && cs_fall && skip_ff;
    endsequence
    sequence s_quad_no_qe;
        opc_done && quad_opc && !quad_enable_bit;
    endsequence

    property p_dual_lanes; // R1
        (st_ff == ST_DATA) && is_dual && (io_oe != 4'h0) |-> io_oe == 4'h3;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual read drives wrong lanes");
    property p_quad_lanes; // R6
        (st_ff == ST_DATA) && !is_dual && (io_oe != 4'h0) |-> io_oe == 4'hf;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad read drives wrong lanes");
    property p_linear; // R2 R19
        push && !wrap_on |=> fetch_addr_ff == $past(step_addr);
    endproperty
    a_linear: assert property (p_linear) else $error("address did not advance by one");
    property p_wrap_section; // R12
        push && wrap_on |=> (fetch_addr_ff & ~cur_mask) == $past(wrap_base);
    endproperty
    a_wrap_section: assert property (p_wrap_section) else $error("wrap left its section");
    property p_skip_clear; // R3 R8 R11
        mode_end && (skip_bits != SKIP_CODE) |=> !skip_ff ##1 !skip_ff || cs_rise || cs_fall;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("skip kept without mode code");
    property p_skip_set; // R4
        mode_end && (skip_bits == SKIP_CODE) |=> skip_ff && skip_kind_ff == $past(kind_ff);
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("skip not armed by mode code");
    property p_skip_entry; // R18
        s_skip_fall |=> st_ff == ST_ADDR && kind_ff == $past(skip_kind_ff);
    endproperty
    a_skip_entry: assert property (p_skip_entry) else $error("skip frame not in address phase");
    property p_qe_gate; // R7 R10
        s_quad_no_qe |=> st_ff == ST_IGNORE [*2] or cs_rise;
    endproperty
    a_qe_gate: assert property (p_qe_gate) else $error("quad read taken without enable");
    property p_mode_reset; // R5
        mode_reset |=> !skip_ff && st_ff == ST_IDLE;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reset left skip set");
    property p_wrap_commit; // R14
        wrap_commit |=> wrap_cfg_ff == $past(pend_ff);
    endproperty
    a_wrap_commit: assert property (p_wrap_commit) else $error("wrap setting not captured");
    property p_wrap_hold; // R13
        !wrap_commit |=> $stable(wrap_cfg_ff);
    endproperty
    a_wrap_hold: assert property (p_wrap_hold) else $error("wrap setting changed by itself");
    property p_wrap_reset; // R16
        !wrap_seen_ff |-> wrap_cfg_ff.dis;
    endproperty
    a_wrap_reset: assert property (p_wrap_reset) else $error("wrap enabled after power-on");
endmodule // flash_read_front

//--- core/flash_read_pkg.sv
// Package: constants, types and states of the multi-line flash read front end
package flash_read_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_DUAL_IO = 8'hbb;
    localparam logic [7:0] OPC_QUAD_IO = 8'heb;
    localparam logic [7:0] OPC_QUAD_WORD = 8'he7;
    localparam logic [7:0] OPC_SET_BURST = 8'h77;
    localparam logic [7:0] OPC_MODE_RESET = 8'hff;

    // ------------------------------------------------------------
    // Phase lengths in serial clocks
    // ------------------------------------------------------------
    localparam logic [4:0] OPC_LAST = 5'd7;
    localparam logic [4:0] ADDR_LAST_DUAL = 5'd15;
    localparam logic [4:0] ADDR_LAST_QUAD = 5'd7;
    localparam logic [4:0] DUMMY_QUAD = 5'd4;
    localparam logic [4:0] DUMMY_WORD = 5'd2;
    localparam logic [4:0] DUMMY_DUAL = 5'd0;
    localparam logic [4:0] WRAP_SLOT = 5'd6;
    localparam logic [4:0] WRAP_CLOCKS = 5'd8;
    localparam logic [1:0] SLOTS_DUAL = 2'd3;
    localparam logic [1:0] SLOTS_QUAD = 2'd1;

    // ------------------------------------------------------------
    // Mode byte and wrap layout
    // ------------------------------------------------------------
    localparam logic [1:0] SKIP_CODE = 2'b10;
    localparam int MODE_SKIP_LO = 4;
    localparam logic [23:0] MASK_8 = 24'h000007;
    localparam logic [23:0] MASK_16 = 24'h00000f;
    localparam logic [23:0] MASK_32 = 24'h00001f;
    localparam logic [23:0] MASK_64 = 24'h00003f;
    localparam logic [23:0] ADDR_STEP = 24'h000001;

    // ------------------------------------------------------------
    // Data path buffer
    // ------------------------------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic dis;
        logic [1:0] len;
    } wrap_cfg_t;

    localparam wrap_cfg_t WRAP_RESET = '{dis: 1'b1, len: 2'b00};

    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] enable;
    } io_drive_t;

    typedef enum logic [1:0] {RK_DUAL, RK_QUAD, RK_WORD} read_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
    } read_state_t;

endpackage

//--- core/stream_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [CW-1:0] cnt_ff;
    wire logic push = ce & in_valid & in_ready & ~flush;
    wire logic pop = ce & out_valid & out_ready & ~flush;

    assign in_ready = (cnt_ff != CW'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_ff[i] <= '0;
            end else if (push && wr_ff == AW'(i)) begin
                mem_ff[i] <= in_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else if (ce && flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= push ? wr_ff + 1'b1 : wr_ff;
            rd_ff <= pop ? rd_ff + 1'b1 : rd_ff;
            cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
        end
    end
endmodule // stream_fifo

//--- verification/spi_host_model.sv
// Host serial controller model: select, serial clock and data lanes
`timescale 1ns/1ns
module spi_host_model (
    output logic cs_n,
    output logic sck,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [3:0] drv = 4'h0;
    logic [3:0] en = 4'h0;
    logic [3:0] junk = 4'h5;
    logic [7:0] rxq[$];
    initial cs_n = 1'b1;
    initial sck = 1'b0;
    // Released lanes toggle so a stale bit never passes for data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = io_oe[i] ? io_out[i] : (en[i] ? drv[i] : junk[i]);
        end
    end
    task automatic tick(input logic [3:0] d, input logic [3:0] e, output logic [3:0] s);
        drv = d;
        en = e;
        junk = ~junk;
        #160 sck = 1'b1;
        #150 s = io_in;
        #10 sck = 1'b0;
    endtask
    task automatic frame(input logic [7:0] opc, input bit on, input logic [31:0] am,
                         input int lanes, input int nam, input int dm, input int nrx);
        logic [3:0] s;
        logic [7:0] b;
        cs_n = 1'b0;
        #200;
        for (int i = 7; i >= 0; i--) if (on) tick({3'b000, opc[i]}, 4'h1, s);
        for (int i = 0; i < nam; i++) begin
            if (lanes == 2) tick({2'b00, am[31-2*i -: 2]}, 4'h3, s);
            else tick(am[31-4*i -: 4], 4'hf, s);
        end
        for (int i = 0; i < dm; i++) tick(4'h0, 4'h0, s);
        for (int k = 0; k < nrx; k++) begin
            for (int j = 0; j < 8 / lanes; j++) begin
                tick(4'h0, 4'h0, s);
                b = (lanes == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
            end
            rxq.push_back(b);
        end
        #160 cs_n = 1'b1;
        #400;
    endtask
endmodule // spi_host_model

//--- verification/tb_top.sv
// Testbench for the multi-line flash read front end
`timescale 1ns/1ns
module tb_top;
    import flash_read_pkg::*;
    typedef struct {logic [7:0] opc; bit on; logic [23:0] a; logic [7:0] md; bit sk;} row_t;
    logic clk = 1'b0, rst_n = 1'b0, qe = 1'b1, cs_n, sck, skip_active, oe_seen = 1'b0;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] mem_addr;
    logic [7:0] mem_data;
    wrap_cfg_t wrap_setting;
    int err_total = 0, n_compared = 0, cycles = 0;
    row_t rows[9] = '{
        '{OPC_DUAL_IO, 1, 24'h0000fe, 8'h00, 0},
        '{OPC_QUAD_IO, 1, 24'h0001fe, 8'h00, 0},
        '{OPC_QUAD_WORD, 1, 24'h0002fe, 8'h00, 0},
        '{OPC_DUAL_IO, 1, 24'h000310, 8'h20, 1},
        '{OPC_DUAL_IO, 0, 24'h000420, 8'hcf, 0},
        '{OPC_QUAD_IO, 1, 24'h000530, 8'ha0, 1},
        '{OPC_QUAD_IO, 0, 24'h000640, 8'h30, 0},
        '{OPC_QUAD_WORD, 1, 24'h000750, 8'h20, 1},
        '{OPC_QUAD_WORD, 0, 24'h000860, 8'h10, 0}};
    // Array stand-in mixes page bits in, so a wrong page shows up
    assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
    initial begin
        forever #20 clk = ~clk;
    end
    spi_host_model u_host (.cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe));
    flash_read_front u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sck(sck),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(qe),
        .mem_addr(mem_addr), .mem_data(mem_data), .skip_active(skip_active),
        .wrap_setting(wrap_setting));
    always @(posedge clk) begin
        cycles++;
        if (io_oe !== 4'h0) oe_seen <= 1'b1;
        if (cycles == 40000) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end
    function automatic logic [7:0] f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] opc, input bit on, input logic [23:0] a,
                      input logic [7:0] md, input int n, input logic [23:0] m);
        int lanes;
        int dm;
        logic [23:0] e;
        lanes = (opc == OPC_DUAL_IO) ? 2 : 4;
        dm = (opc == OPC_QUAD_IO) ? 4 : ((opc == OPC_QUAD_WORD) ? 2 : 0);
        u_host.frame(opc, on, {a, md}, lanes, 32 / lanes, dm, n);
        for (int k = 0; k < n; k++) begin
            e = (a & ~m) | ((a + k) & m);
            check({16'h0, u_host.rxq.pop_front()}, {16'h0, f(e)}, "byte");
        end
    endtask
    task automatic burst(input logic dis, input logic [1:0] l);
        u_host.frame(OPC_SET_BURST, 1, {24'h0, 1'b0, l, dis, 4'h0}, 4, 8, 0, 0);
        check({21'h0, wrap_setting}, {21'h0, dis, l}, "wrap setting");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check({21'h0, wrap_setting}, 24'h4, "wrap at reset");
        check({io_oe, 19'h0, skip_active} | mem_addr, 24'h0, "outputs at reset");
        $display("reset test done");
        foreach (rows[i]) begin
            rd(rows[i].opc, rows[i].on, rows[i].a, rows[i].md, 6, 24'hffffff);
            check({23'h0, skip_active}, {23'h0, rows[i].sk}, "skip state");
        end
        $display("table test done");
        for (int l = 0; l < 4; l++) begin
            burst(1'b0, l[1:0]);
            rd(l == 3 ? OPC_QUAD_WORD : OPC_QUAD_IO, 1, 24'h00a0a6 + 2 * l, 8'h00, 70,
               (24'h8 << l) - 24'h1);
        end
        burst(1'b1, 2'b10);
        rd(OPC_QUAD_IO, 1, 24'h00a0fc, 8'h00, 8, 24'hffffff);
        $display("wrap test done");
        rd(OPC_QUAD_IO, 1, 24'h000b00, 8'h20, 2, 24'hffffff);
        u_host.frame(8'h00, 0, 32'hffffffff, 4, 2, 0, 0);
        check({23'h0, skip_active}, 24'h0, "skip after mode reset");
        rd(OPC_QUAD_IO, 1, 24'h000c00, 8'h00, 2, 24'hffffff);
        $display("mode reset test done");
        @(negedge clk);
        qe = 1'b0;
        oe_seen = 1'b0;
        rd(OPC_QUAD_IO, 1, 24'h0, 8'h0, 0, 24'hffffff);
        rd(OPC_QUAD_WORD, 1, 24'h0, 8'h0, 0, 24'hffffff);
        check({23'h0, oe_seen}, 24'h0, "lines driven without quad enable");
        $display("quad enable test done");
        tally_and_finish();
    end
endmodule // tb_top
